// ===== core/dac_external_update_trigger.sv
// Overview of operation
// - Trigger input updates only analog output channels.
// - Trigger is passed to board timing bus.
// - Each falling trigger edge outside a strobe and the cycle after it makes one strobe.
// - Strobe fall loads selected double-buffered channels.
// - Strobe rise requests new data or interrupt.
// - Edges act only when external update selected.
// - Update interrupt has own enable and clear.
`timescale 1ns/1ps
`default_nettype none
module dac_external_update_trigger
	import ext_update_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS,
	parameter int WIDTH = CODE_WIDTH,
	parameter int LOW_CYCLES = STROBE_LOW_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ext_update_trigger_n,
	input wire logic ext_update_select,
	input wire logic [CHANNELS-1:0] channel_select,
	input wire logic [CHANNELS-1:0] double_buffered,
	input wire logic [CHANNELS*WIDTH-1:0] buffered_codes,
	input wire logic data_request_enable,
	input wire logic update_irq_enable,
	input wire logic update_irq_clear,
	output logic board_timing_bus,
	output logic internal_update_strobe_n,
	output logic [CHANNELS*WIDTH-1:0] output_codes,
	output logic new_data_request,
	output logic update_irq
);
	localparam int CNT_W = $clog2(LOW_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOW_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(LOW_CYCLES);

	// Refuse parameter values that the counters and slices cannot serve.
	if (CHANNELS < 1 || WIDTH < 1 || LOW_CYCLES < 1) begin : g_param_check
		$error("channel count, code width and low time must be >= 1");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchroniser and edge detection.

	logic trig_sync;
	logic trig_prev_q;
	logic fall_edge;

	// The synchroniser resets high because the line idles high.
	trigger_sync #(
		.STAGES(SYNC_STAGES),
		.RESET_LEVEL(1'b1)
	) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(ext_update_trigger_n),
		.sync_out(trig_sync)
	);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			trig_prev_q <= 1'b1;
		end else begin
			trig_prev_q <= trig_sync;
		end
	end

	// A high-to-low transition is the only request; a line held low or high starts nothing.
	assign fall_edge = trig_prev_q & ~trig_sync;

	// The synchronised trigger is shared with the other boards.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			board_timing_bus <= 1'b1;
		end else begin
			board_timing_bus <= trig_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobe generator.

	strobe_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic strobe_fall;
	logic strobe_rise;

	// An edge that arrives during a strobe is ignored so each strobe
	// stays one clean pulse.
	assign strobe_fall = (state_q == STROBE_IDLE) & fall_edge
		& ext_update_select;
	assign strobe_rise = (state_q == STROBE_LOW) & (cnt_q == CNT_LAST);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_q <= STROBE_IDLE;
			cnt_q <= CNT_ZERO;
		end else begin
			case (state_q)
				STROBE_IDLE: begin
					cnt_q <= CNT_ZERO;
					if (strobe_fall) begin
						state_q <= STROBE_LOW;
					end
				end
				STROBE_LOW: begin
					if (strobe_rise) begin
						state_q <= STROBE_RISE;
						cnt_q <= CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				STROBE_RISE: begin
					state_q <= STROBE_IDLE;
				end
				default: begin
					state_q <= STROBE_IDLE;
					cnt_q <= CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			internal_update_strobe_n <= 1'b1;
		end else if (strobe_fall) begin
			internal_update_strobe_n <= 1'b0;
		end else if (strobe_rise) begin
			internal_update_strobe_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel output load on the strobe's falling edge.

	// Only the converter outputs are touched by this trigger.
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					output_codes[ch*WIDTH +: WIDTH] <= '0;
				end else if (strobe_fall && channel_select[ch]
						&& double_buffered[ch]) begin
					output_codes[ch*WIDTH +: WIDTH] <=
						buffered_codes[ch*WIDTH +: WIDTH];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Requests on the strobe's rising edge.

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			new_data_request <= 1'b0;
		end else begin
			new_data_request <= strobe_rise & data_request_enable;
		end
	end

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			update_irq <= 1'b0;
		end else if (strobe_rise && update_irq_enable) begin
			update_irq <= 1'b1;
		end else if (update_irq_clear) begin
			update_irq <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	// Counts the cycles for which the strobe has been seen low.
	logic [CNT_W-1:0] low_len_q;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			low_len_q <= CNT_ZERO;
		end else if (!internal_update_strobe_n) begin
			low_len_q <= low_len_q + CNT_W'(1);
		end else begin
			low_len_q <= CNT_ZERO;
		end
	end

	property p_strobe_on_edge;
		@(posedge mclk) disable iff (!reset_n)
		(internal_update_strobe_n && $fell(trig_sync) && trig_prev_q
			&& state_q == STROBE_IDLE && ext_update_select)
			|=> !internal_update_strobe_n;
	endproperty
	a_strobe_on_edge: assert property (p_strobe_on_edge)
		else $error("falling trigger edge gave no strobe");

	property p_no_strobe_unselected;
		@(posedge mclk) disable iff (!reset_n)
		(internal_update_strobe_n && !ext_update_select)
			|=> internal_update_strobe_n;
	endproperty
	a_no_strobe_unselected: assert property (p_no_strobe_unselected)
		else $error("strobe started while external update not selected");

	property p_strobe_width;
		@(posedge mclk) disable iff (!reset_n)
		$rose(internal_update_strobe_n) |-> low_len_q == CNT_FULL;
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("strobe low time wrong");

	property p_strobe_not_long;
		@(posedge mclk) disable iff (!reset_n)
		!internal_update_strobe_n |-> low_len_q != CNT_FULL;
	endproperty
	a_strobe_not_long: assert property (p_strobe_not_long)
		else $error("strobe stayed low too long");

	property p_load_on_fall;
		@(posedge mclk) disable iff (!reset_n)
		(strobe_fall && channel_select[0] && double_buffered[0])
			|=> output_codes[WIDTH-1:0] == $past(buffered_codes[WIDTH-1:0]);
	endproperty
	a_load_on_fall: assert property (p_load_on_fall)
		else $error("selected channel not loaded on strobe fall");

	property p_hold_unselected;
		@(posedge mclk) disable iff (!reset_n)
		!channel_select[0] |=> $stable(output_codes[WIDTH-1:0]);
	endproperty
	a_hold_unselected: assert property (p_hold_unselected)
		else $error("unselected channel output changed");

	property p_request_on_rise;
		@(posedge mclk) disable iff (!reset_n)
		$rose(internal_update_strobe_n)
			|-> new_data_request == $past(data_request_enable);
	endproperty
	a_request_on_rise: assert property (p_request_on_rise)
		else $error("data request does not follow strobe rise");

	property p_irq_clear;
		@(posedge mclk) disable iff (!reset_n)
		(update_irq_clear && !strobe_rise) |=> !update_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt not cleared");

	property p_irq_set_wins;
		@(posedge mclk) disable iff (!reset_n)
		(strobe_rise && update_irq_enable) |=> update_irq;
	endproperty
	a_irq_set_wins: assert property (p_irq_set_wins)
		else $error("enabled update interrupt not raised");

	property p_bus_follows;
		@(posedge mclk) disable iff (!reset_n)
		##1 board_timing_bus == $past(trig_sync);
	endproperty
	a_bus_follows: assert property (p_bus_follows)
		else $error("timing bus does not follow trigger");
endmodule : dac_external_update_trigger
`default_nettype wire

// ===== core/ext_update_pkg.sv
package ext_update_pkg;
	// Number of analog output channels served by the update strobe.
	localparam int NUM_CHANNELS = 10;
	// Width of one converter code.
	localparam int CODE_WIDTH = 12;
	// Low time of the internal update strobe, in nanoseconds.
	localparam int STROBE_LOW_NS = 50;
	// Clock period in picoseconds; the clock runs at 200 MHz.
	localparam int CLK_PERIOD_PS = 5000;
	// The low time is a least time, so the count rounds up.
	localparam int STROBE_LOW_CYCLES =
		(STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Stages of the input synchroniser.
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		STROBE_IDLE = 2'b00,
		STROBE_LOW = 2'b01,
		STROBE_RISE = 2'b10
	} strobe_state_t;
endpackage : ext_update_pkg

// ===== core/trigger_sync.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_sync #(
	parameter int STAGES = 2,
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic async_in,
	output logic sync_out
);
	logic [STAGES-1:0] chain_q;

	// A single stage would not settle a metastable sample.
	if (STAGES < 2) begin : g_stage_check
		$error("trigger_sync needs at least two stages");
	end

	// Only the last stage is read outside the chain.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			chain_q <= {STAGES{RESET_LEVEL}};
		end else begin
			chain_q <= {chain_q[STAGES-2:0], async_in};
		end
	end

	assign sync_out = chain_q[STAGES-1];
endmodule : trigger_sync
`default_nettype wire

// ===== verification/ext_trigger_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_trigger_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [7:0] low_len,
	output logic trig_n
);
	logic [7:0] left_q = 8'h00;

	// The instrument only ever pulls the line low; released, the pull-up wins.
	always @(negedge mclk) begin
		if (go) begin
			left_q <= low_len;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	assign trig_n = (left_q != 8'h00) ? 1'b0 : 1'b1;
endmodule : ext_trigger_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ext_update_pkg::*;
	localparam int CH = NUM_CHANNELS;
	localparam int W = CODE_WIDTH;
	localparam int CW = CH * W;
	localparam int LOW = 4;
	logic mclk = 1'b0, reset_n = 1'b0, go = 1'b0, trig_n, sel_ext = 1'b0;
	logic [CH-1:0] ch_sel = '0, dbuf = '0;
	logic [CW-1:0] codes = '0, out_codes, model_codes = '0;
	logic req_en = 1'b0, irq_en = 1'b0, irq_clr = 1'b0;
	logic bus, strobe_n, req, irq;
	int bad_count = 0, num_checks = 0, cycles = 0;

	ext_trigger_model i_inst (.mclk(mclk), .go(go), .low_len(8'h06),
		.trig_n(trig_n));
	dac_external_update_trigger #(.LOW_CYCLES(LOW)) i_dut (.mclk(mclk),
		.reset_n(reset_n), .ext_update_trigger_n(trig_n),
		.ext_update_select(sel_ext), .channel_select(ch_sel),
		.double_buffered(dbuf), .buffered_codes(codes),
		.data_request_enable(req_en), .update_irq_enable(irq_en),
		.update_irq_clear(irq_clr), .board_timing_bus(bus),
		.internal_update_strobe_n(strobe_n), .output_codes(out_codes),
		.new_data_request(req), .update_irq(irq));

	////////////////////////////////////////////////////////////////////////
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [CW+3:0] seen,
			input logic [CW+3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Fires one trigger fall and returns with the strobe seen low, or not.
	task automatic fire(output int n);
		for (int c = 0; c < CH; c++) begin
			if (sel_ext && ch_sel[c] && dbuf[c]) begin
				model_codes[c*W +: W] = codes[c*W +: W];
			end
		end
		go <= 1'b1;
		@(negedge mclk);
		go <= 1'b0;
		n = 0;
		while (strobe_n !== 1'b0 && n < 12) begin
			@(negedge mclk);
			n++;
		end
	endtask : fire

	task automatic update(input logic exp_req, input logic exp_irq,
			input logic clr_at_rise);
		int n, m;
		fire(n);
		check((n == 3) || (n == 4), 1'b1);
		check(bus, 1'b0);
		check(out_codes, model_codes);
		m = 0;
		while (strobe_n === 1'b0 && m < 40) begin
			// A clear held across the rise edge must lose to the set.
			irq_clr = clr_at_rise && (m == LOW - 1);
			@(negedge mclk);
			m++;
		end
		irq_clr = 1'b0;
		check(m, LOW);
		check({req, irq}, {exp_req, exp_irq});
		@(negedge mclk);
		check(req, 1'b0);
		repeat (8) @(negedge mclk);
		check({strobe_n, bus, irq}, {2'b11, exp_irq});
	endtask : update

	////////////////////////////////////////////////////////////////////////
	task automatic t_update_irq;
		sel_ext = 1'b1;
		ch_sel = 10'h2B3;
		dbuf = 10'h3C7;
		req_en = 1'b1;
		irq_en = 1'b1;
		for (int c = 0; c < CH; c++) codes[c*W +: W] = 12'h111 * c + 12'h001;
		update(1'b1, 1'b1, 1'b1);
		irq_clr = 1'b1;
		@(negedge mclk);
		irq_clr = 1'b0;
		@(negedge mclk);
		check(irq, 1'b0);
		$display("Test update_irq done");
	endtask : t_update_irq

	task automatic t_gated;
		req_en = 1'b0;
		irq_en = 1'b0;
		ch_sel = 10'h35C;
		dbuf = 10'h1F8;
		codes = ~codes;
		update(1'b0, 1'b0, 1'b0);
		$display("Test gated done");
	endtask : t_gated

	task automatic t_unselected;
		int n;
		sel_ext = 1'b0;
		req_en = 1'b1;
		irq_en = 1'b1;
		codes = {CW{1'b1}};
		fire(n);
		check(n, 12);
		repeat (LOW + 4) @(negedge mclk);
		check({out_codes, req, irq}, {model_codes, 2'b00});
		$display("Test unselected done");
	endtask : t_unselected

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (6) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		check({strobe_n, bus, req, irq, out_codes}, {4'b1100, {CW{1'b0}}});
		t_update_irq();
		t_gated();
		t_unselected();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
